// [logic/i2c_seg_consts.svh]
`ifndef I2C_SEG_CONSTS_SVH
`define I2C_SEG_CONSTS_SVH

// register byte offsets
`define OFS_DATA        8'h00
`define OFS_CTRL_ONE    8'h04
`define OFS_CTRL_TWO    8'h08
`define OFS_STATUS      8'h0C
`define OFS_INT_FLAGS   8'h10
`define OFS_INT_MASK    8'h14

// bus_control_one request bits
`define REQ_START       0
`define REQ_SEND        1
`define REQ_RECV        2
`define REQ_STOP        3

// bus_status bits
`define FIN_CMD         0
`define FIN_TX          1
`define FIN_RX          2
`define FIN_NACK        3

// interrupt flag and mask bits
`define EV_CMD          0
`define EV_TX           1
`define EV_RX           2
`define EV_NACK         3
`define EV_OVERRUN      4
`define EV_UNDERRUN     5
`define EV_WIDTH        6

// reset values
`define INT_MASK_RESET  6'h00
`define ACK_SEL_RESET   1'b0

// timing: one bus bit is four quarters
`define CLK_PERIOD_NS   4
`define BIT_TIME_NS     10000
`define QUARTER_CYCLES  ((`BIT_TIME_NS / 4 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ACK_SLOT        4'h8

`endif

// [logic/i2c_seg_pkg.sv]
package i2c_seg_pkg;

  typedef logic [7:0]  addr_t;
  typedef logic [31:0] word_t;

  // segment currently in progress
  typedef enum logic [2:0] {
    SEG_IDLE  = 3'b000,
    SEG_START = 3'b001,
    SEG_SEND  = 3'b010,
    SEG_RECV  = 3'b011,
    SEG_STOP  = 3'b100
  } seg_e;

endpackage : i2c_seg_pkg

// [logic/i2c_master_segment_controller.sv]
`timescale 1ns/1ns
`default_nettype none
`include "i2c_seg_consts.svh"

module i2c_master_segment_controller (
  input  wire logic               clock,
  input  wire logic               resetn,
  input  wire i2c_seg_pkg::addr_t reg_addr,
  input  wire i2c_seg_pkg::word_t reg_wdata,
  input  wire logic               reg_write,
  input  wire logic               reg_read,
  output var  i2c_seg_pkg::word_t reg_rdata,
  output logic                    irq,
  input  wire logic               scl_in,
  output logic                    scl_out,
  output logic                    scl_oe,
  input  wire logic               sda_in,
  output logic                    sda_out,
  output logic                    sda_oe
);
  import i2c_seg_pkg::*;

  localparam logic [9:0] QLAST = 10'(`QUARTER_CYCLES - 1);

  function automatic logic reg_hit(input addr_t a, input addr_t ofs);
    reg_hit = (a == ofs);
  endfunction : reg_hit

  seg_e                 seg_reg;
  logic [1:0]           quarter_reg;
  logic [3:0]           bit_reg;
  logic [9:0]           div_reg;
  logic [7:0]           tx_data_reg;
  logic [7:0]           tx_shift_reg;
  logic [7:0]           rx_shift_reg;
  logic [7:0]           rx_data_reg;
  logic                 tx_valid_reg;
  logic                 rx_full_reg;
  logic                 ack_select_reg;
  logic                 ack_sample_reg;
  logic [3:0]           fin_reg;
  logic [2:0]           fin_prev_reg;
  logic [`EV_WIDTH-1:0] int_flags_reg;
  logic [`EV_WIDTH-1:0] int_flags_next;
  logic [`EV_WIDTH-1:0] int_mask_reg;
  logic [`EV_WIDTH-1:0] events;
  logic                 scl_low_reg;
  logic                 sda_low_reg;
  logic [2:0]           scl_sync_reg;
  logic [2:0]           sda_sync_reg;
  logic                 scl_level_reg;
  logic                 sda_level_reg;
  logic                 wr_ctrl_one;
  logic                 req_ok;
  logic                 step;
  logic                 seg_done;
  logic                 bit_end;
  logic [3:0]           req;
  logic [3:0]           req_view;

  // register strobes and request acceptance
  assign req         = reg_wdata[3:0];
  assign wr_ctrl_one = reg_write && reg_hit(reg_addr, `OFS_CTRL_ONE);
  // two bits at once, or a request while busy, is refused outright
  assign req_ok      = wr_ctrl_one && (seg_reg == SEG_IDLE) && $onehot(req);

  // a quarter ends after its count; the end of quarter one waits for scl high
  assign step     = (seg_reg != SEG_IDLE) && (div_reg == QLAST)
                    && !((quarter_reg == 2'h1) && !scl_level_reg);
  assign bit_end  = step && (quarter_reg == 2'h3);
  assign seg_done = bit_end && ((seg_reg == SEG_START) || (seg_reg == SEG_STOP)
                    || (bit_reg == `ACK_SLOT));

  // open-drain lines: drive low or release
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe  = scl_low_reg;
  assign sda_oe  = sda_low_reg;

  // pin sampling: a level change counts once the second and third stage agree
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      scl_sync_reg  <= 3'h7;
      sda_sync_reg  <= 3'h7;
      scl_level_reg <= 1'b1;
      sda_level_reg <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
      sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
      if (scl_sync_reg[1] == scl_sync_reg[2]) begin
        scl_level_reg <= scl_sync_reg[2];
      end
      if (sda_sync_reg[1] == sda_sync_reg[2]) begin
        sda_level_reg <= sda_sync_reg[2];
      end
    end
  end

  // quarter divider; holds at its end while a slave stretches scl
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      div_reg <= 10'h000;
    end else if ((seg_reg == SEG_IDLE) || step) begin
      div_reg <= 10'h000;
    end else if (div_reg != QLAST) begin
      div_reg <= div_reg + 10'h001;
    end
  end

  // segment state: one pending segment at most
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      seg_reg     <= SEG_IDLE;
      quarter_reg <= 2'h0;
      bit_reg     <= 4'h0;
    end else if (req_ok) begin
      quarter_reg <= 2'h0;
      bit_reg     <= 4'h0;
      case (1'b1)
        req[`REQ_START]: seg_reg <= SEG_START;
        req[`REQ_SEND]:  seg_reg <= SEG_SEND;
        req[`REQ_RECV]:  seg_reg <= SEG_RECV;
        default:         seg_reg <= SEG_STOP;
      endcase
    end else if (seg_done) begin
      seg_reg <= SEG_IDLE;
    end else if (step) begin
      quarter_reg <= quarter_reg + 2'h1;
      if (quarter_reg == 2'h3) begin
        bit_reg <= bit_reg + 4'h1;
      end
    end
  end

  // line drivers; frame order is up to software, so a stop from idle is not guarded
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      scl_low_reg <= 1'b0;
      sda_low_reg <= 1'b0;
    end else if (req_ok) begin
      case (1'b1)
        req[`REQ_START]: sda_low_reg <= 1'b0;
        req[`REQ_SEND]:  sda_low_reg <= ~tx_data_reg[7];
        req[`REQ_RECV]:  sda_low_reg <= 1'b0;
        default:         sda_low_reg <= 1'b1;
      endcase
    end else if (step) begin
      case (seg_reg)
        SEG_START: begin
          if (quarter_reg == 2'h0) scl_low_reg <= 1'b0;
          if (quarter_reg == 2'h1) sda_low_reg <= 1'b1;
          if (quarter_reg == 2'h2) scl_low_reg <= 1'b1;
        end
        SEG_STOP: begin
          if (quarter_reg == 2'h0) scl_low_reg <= 1'b0;
          if (quarter_reg == 2'h2) sda_low_reg <= 1'b0;
        end
        SEG_SEND: begin
          if (quarter_reg == 2'h0) scl_low_reg <= 1'b1 ^ 1'b1;
          if (quarter_reg == 2'h2) scl_low_reg <= 1'b1;
          if ((quarter_reg == 2'h3) && (bit_reg != `ACK_SLOT)) begin
            // the slave owns sda in the ack slot
            sda_low_reg <= (bit_reg == 4'h7) ? 1'b0 : ~tx_shift_reg[6];
          end
        end
        SEG_RECV: begin
          if (quarter_reg == 2'h0) scl_low_reg <= 1'b0;
          if (quarter_reg == 2'h2) scl_low_reg <= 1'b1;
          if ((quarter_reg == 2'h3) && (bit_reg == 4'h7)) begin
            sda_low_reg <= ack_select_reg;
          end else if ((quarter_reg == 2'h3) && (bit_reg == `ACK_SLOT)) begin
            sda_low_reg <= 1'b0;
          end
        end
        default: begin
          scl_low_reg <= scl_low_reg;
        end
      endcase
    end
  end

  // shifters and ack sample; bytes move msb first
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      tx_shift_reg   <= 8'h00;
      rx_shift_reg   <= 8'h00;
      ack_sample_reg <= 1'b0;
    end else if (req_ok && req[`REQ_SEND]) begin
      tx_shift_reg <= tx_data_reg;
    end else if (step && (seg_reg == SEG_SEND) && (quarter_reg == 2'h3)) begin
      tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
    end else if (step && (quarter_reg == 2'h1) && (bit_reg == `ACK_SLOT)) begin
      ack_sample_reg <= sda_level_reg;
    end else if (step && (seg_reg == SEG_RECV) && (quarter_reg == 2'h1)) begin
      rx_shift_reg <= {rx_shift_reg[6:0], sda_level_reg};
    end
  end

  // serial data register: writes feed the sender, reads return the received byte
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      tx_data_reg  <= 8'h00;
      tx_valid_reg <= 1'b0;
      rx_data_reg  <= 8'h00;
      rx_full_reg  <= 1'b0;
    end else begin
      if (reg_write && reg_hit(reg_addr, `OFS_DATA)) begin
        tx_data_reg  <= reg_wdata[7:0];
        tx_valid_reg <= 1'b1;
      end else if (req_ok && req[`REQ_SEND]) begin
        tx_valid_reg <= 1'b0;
      end
      // a full slot keeps its byte; the new one is dropped
      if (seg_done && (seg_reg == SEG_RECV) && !rx_full_reg) begin
        rx_data_reg <= rx_shift_reg;
        rx_full_reg <= 1'b1;
      end else if (reg_read && reg_hit(reg_addr, `OFS_DATA)) begin
        rx_full_reg <= 1'b0;
      end
    end
  end

  // finished flags; a new request clears cmd, tx and rx, while the nack bit stays until a send or receive ends
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      fin_reg      <= 4'h0;
      fin_prev_reg <= 3'h0;
    end else begin
      fin_prev_reg <= fin_reg[2:0];
      if (req_ok) begin
        fin_reg[2:0] <= 3'h0;
      end else if (seg_done) begin
        case (seg_reg)
          SEG_SEND: begin
            fin_reg[`FIN_TX]   <= 1'b1;
            fin_reg[`FIN_NACK] <= ack_sample_reg;
          end
          SEG_RECV: begin
            fin_reg[`FIN_RX]   <= 1'b1;
            fin_reg[`FIN_NACK] <= ack_sample_reg;
          end
          default: fin_reg[`FIN_CMD] <= 1'b1;
        endcase
      end
    end
  end

  // events: flag rises, nack on send, overrun, underrun
  always_comb begin
    events               = {`EV_WIDTH{1'b0}};
    events[`EV_CMD]      = fin_reg[`FIN_CMD] & ~fin_prev_reg[`FIN_CMD];
    events[`EV_TX]       = fin_reg[`FIN_TX] & ~fin_prev_reg[`FIN_TX];
    events[`EV_RX]       = fin_reg[`FIN_RX] & ~fin_prev_reg[`FIN_RX];
    events[`EV_NACK]     = seg_done && (seg_reg == SEG_SEND) && ack_sample_reg;
    events[`EV_OVERRUN]  = seg_done && (seg_reg == SEG_RECV) && rx_full_reg;
    events[`EV_UNDERRUN] = req_ok && req[`REQ_SEND] && !tx_valid_reg;
    // write one to clear, but a new event in the same cycle wins
    int_flags_next = int_flags_reg;
    if (reg_write && reg_hit(reg_addr, `OFS_INT_FLAGS)) begin
      int_flags_next = int_flags_reg & ~reg_wdata[`EV_WIDTH-1:0];
    end
    int_flags_next = int_flags_next | events;
  end

  // interrupt flags, mask and ack choice
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      int_flags_reg  <= {`EV_WIDTH{1'b0}};
      int_mask_reg   <= `INT_MASK_RESET;
      ack_select_reg <= `ACK_SEL_RESET;
    end else begin
      int_flags_reg <= int_flags_next;
      if (reg_write && reg_hit(reg_addr, `OFS_INT_MASK)) begin
        int_mask_reg <= reg_wdata[`EV_WIDTH-1:0];
      end
      if (reg_write && reg_hit(reg_addr, `OFS_CTRL_TWO)) begin
        ack_select_reg <= reg_wdata[0];
      end
    end
  end

  // the top-level enable lives in the interrupt controller outside
  assign irq = |(int_flags_reg & int_mask_reg);

  // request bits read back as the pending segment
  always_comb begin
    req_view = 4'h0;
    case (seg_reg)
      SEG_START: req_view[`REQ_START] = 1'b1;
      SEG_SEND:  req_view[`REQ_SEND]  = 1'b1;
      SEG_RECV:  req_view[`REQ_RECV]  = 1'b1;
      SEG_STOP:  req_view[`REQ_STOP]  = 1'b1;
      default:   req_view = 4'h0;
    endcase
  end

  // read data stand one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_read) begin
      case (reg_addr)
        `OFS_DATA:      reg_rdata <= {24'h000000, rx_data_reg};
        `OFS_CTRL_ONE:  reg_rdata <= {28'h0000000, req_view};
        `OFS_CTRL_TWO:  reg_rdata <= {31'h00000000, ack_select_reg};
        `OFS_STATUS:    reg_rdata <= {28'h0000000, fin_reg};
        `OFS_INT_FLAGS: reg_rdata <= {26'h0000000, int_flags_reg};
        `OFS_INT_MASK:  reg_rdata <= {26'h0000000, int_mask_reg};
        default:        reg_rdata <= 32'h00000000;
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

  a_single_pending: assert property (
    @(posedge clock) disable iff (!resetn)
    $onehot0(req_view))
    else $error("more than one segment pending");

  a_ack_drive: assert property (
    @(posedge clock) disable iff (!resetn)
    (seg_reg == SEG_RECV) && (bit_reg == `ACK_SLOT) && (quarter_reg == 2'h1)
    |-> (sda_oe == ack_select_reg))
    else $error("receive ack slot not driven per ack_select");

  a_cmd_done: assert property (
    @(posedge clock) disable iff (!resetn)
    seg_done && ((seg_reg == SEG_START) || (seg_reg == SEG_STOP))
    |=> (req_view == 4'h0) && fin_reg[`FIN_CMD] ##1 int_flags_reg[`EV_CMD])
    else $error("command finish or its event missing");

  a_send_done: assert property (
    @(posedge clock) disable iff (!resetn)
    seg_done && (seg_reg == SEG_SEND)
    |=> !req_view[`REQ_SEND] && fin_reg[`FIN_TX] ##1 int_flags_reg[`EV_TX])
    else $error("send finish or its event missing");

  a_recv_done: assert property (
    @(posedge clock) disable iff (!resetn)
    seg_done && (seg_reg == SEG_RECV) && !rx_full_reg
    |=> rx_full_reg && fin_reg[`FIN_RX] && (rx_data_reg == $past(rx_shift_reg)))
    else $error("received byte not held");

  a_nack_event: assert property (
    @(posedge clock) disable iff (!resetn)
    seg_done && (seg_reg == SEG_SEND) && ack_sample_reg
    |=> int_flags_reg[`EV_NACK] && fin_reg[`FIN_NACK])
    else $error("nack after send not reported");

  a_overrun_keep: assert property (
    @(posedge clock) disable iff (!resetn)
    seg_done && (seg_reg == SEG_RECV) && rx_full_reg
    |=> int_flags_reg[`EV_OVERRUN] && $stable(rx_data_reg))
    else $error("overrun not flagged or byte overwritten");

  a_underrun_flag: assert property (
    @(posedge clock) disable iff (!resetn)
    req_ok && req[`REQ_SEND] && !tx_valid_reg |=> int_flags_reg[`EV_UNDERRUN])
    else $error("underrun not flagged");

  a_irq_masked: assert property (
    @(posedge clock) disable iff (!resetn)
    $rose(int_flags_reg[`EV_RX]) && !int_mask_reg[`EV_RX] && ((int_flags_reg & int_mask_reg) == 6'h00)
    |-> !irq)
    else $error("masked event reached irq");

  a_data_read: assert property (
    @(posedge clock) disable iff (!resetn)
    reg_read && (reg_addr == `OFS_DATA) |=> (reg_rdata[7:0] == $past(rx_data_reg)))
    else $error("data read does not return received byte");

endmodule : i2c_master_segment_controller
`default_nettype wire

// [bench/i2c_slave_model.sv]
`timescale 1ns/1ns
`default_nettype none

// behavioural slave on the two-wire bus; open-drain, lines pulled up by the bench
module i2c_slave_model (
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic       tx_mode,
  input  wire logic [7:0] tx_byte,
  input  wire logic       nack_cmd,
  input  wire logic       stretch,
  output logic            sda_low,
  output logic            scl_low,
  output logic [7:0]      got_byte,
  output logic            ack_seen
);
  logic [3:0] bit_cnt;

  initial begin
    bit_cnt  = 4'h9;
    scl_low  = 1'b0;
    got_byte = 8'h00;
    ack_seen = 1'b1;
  end

  // start or stop: sda moves while scl is high; both park the bit counter
  always @(sda) begin
    if (scl === 1'b1) bit_cnt = 4'h9;
  end

  // sample on rising scl: eight data bits msb first, then the ack slot
  always @(posedge scl) begin
    if (bit_cnt < 4'h8) got_byte = {got_byte[6:0], sda};
    else if (bit_cnt == 4'h8) ack_seen = sda;
  end

  // advance on falling scl; stretching outlasts the master's own low time
  always @(negedge scl) begin
    bit_cnt = (bit_cnt >= 4'h8) ? 4'h0 : bit_cnt + 4'h1;
    if (stretch) begin
      scl_low = 1'b1;
      #6000 scl_low = 1'b0;
    end
  end

  // data bits when answering a read, ack slot when being written; nack on command
  assign sda_low = (tx_mode && bit_cnt < 4'h8 && !tx_byte[3'h7 - bit_cnt[2:0]])
                 || (!tx_mode && bit_cnt == 4'h8 && !nack_cmd);
endmodule : i2c_slave_model

`default_nettype wire

// [bench/i2c_master_segment_controller_test.sv]
`timescale 1ns/1ns
`default_nettype none
`include "i2c_seg_consts.svh"

module i2c_master_segment_controller_test;
  import i2c_seg_pkg::*;

  typedef struct { logic wr; addr_t addr; word_t data; word_t exp; } row_s;

  logic       clock     = 1'b0;
  logic       resetn    = 1'b0;
  addr_t      reg_addr  = 8'h00;
  word_t      reg_wdata = 32'h0;
  logic       reg_write = 1'b0;
  logic       reg_read  = 1'b0;
  word_t      reg_rdata;
  logic       irq;
  logic       scl_out;
  logic       scl_oe;
  logic       sda_out;
  logic       sda_oe;
  logic       tx_mode   = 1'b0;
  logic       nack_cmd  = 1'b0;
  logic       stretch   = 1'b0;
  logic       sda_low;
  logic       scl_low;
  logic [7:0] got_byte;
  logic       ack_seen;
  word_t      rd;
  int         n_mismatch = 0;
  int         checked    = 0;
  int         cycles     = 0;
  // pulled-up wires: low while any party pulls
  wire logic  scl_wire = ~(scl_oe | scl_low);
  wire logic  sda_wire = ~(sda_oe | sda_low);

  always #2 clock = ~clock;

  i2c_master_segment_controller dut_u (
    .clock(clock), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .irq(irq),
    .scl_in(scl_wire), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe)
  );

  i2c_slave_model slave_u (
    .scl(scl_wire), .sda(sda_wire), .tx_mode(tx_mode), .tx_byte(8'h5A),
    .nack_cmd(nack_cmd), .stretch(stretch), .sda_low(sda_low), .scl_low(scl_low),
    .got_byte(got_byte), .ack_seen(ack_seen)
  );

  task automatic summarize();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize

  task automatic check(input string name, input word_t seen, input word_t exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic reg_wr(input addr_t a, input word_t d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : reg_wr

  // read data stand only in the cycle after the strobe
  task automatic reg_rd(input addr_t a, output word_t d);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask : reg_rd

  task automatic chk_reg(input string name, input addr_t a, input word_t exp);
    word_t v;
    reg_rd(a, v);
    check(name, v, exp);
  endtask : chk_reg

  // polls the request bits under a bound; the cycle ceiling catches a hang too
  task automatic wait_idle();
    word_t v;
    v = 32'h1;
    for (int i = 0; i < 40000 && v !== 32'h0; i++) reg_rd(`OFS_CTRL_ONE, v);
    check("ctrl_one idle", v, 32'h0);
  endtask : wait_idle

  task automatic irq_is(input logic exp);
    repeat (2) @(posedge clock);
    #1 check("irq", {31'h0, irq}, {31'h0, exp});
  endtask : irq_is

  // cut a hang short
  always @(posedge clock) begin
    cycles++;
    if (cycles == 100000) begin
      n_mismatch++;
      summarize();
    end
  end

  initial begin
    row_s rows[11];
    rows = '{
      '{1'b0, `OFS_CTRL_ONE,  32'h0, 32'h0},  '{1'b0, `OFS_STATUS, 32'h0, 32'h0},
      '{1'b0, `OFS_INT_FLAGS, 32'h0, 32'h0},  '{1'b0, `OFS_INT_MASK, 32'h0, 32'h0},
      '{1'b1, `OFS_INT_MASK,  32'h3F, 32'h0}, '{1'b0, `OFS_INT_MASK, 32'h0, 32'h3F},
      '{1'b0, 8'h20,          32'h0, 32'h0},  '{1'b1, `OFS_CTRL_ONE, 32'h3, 32'h0},
      '{1'b0, `OFS_CTRL_ONE,  32'h0, 32'h0},  '{1'b1, `OFS_CTRL_TWO, 32'h1, 32'h0},
      '{1'b0, `OFS_CTRL_TWO,  32'h0, 32'h1}};
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    #1 check("irq after reset", {31'h0, irq}, 32'h0);
    check("lines after reset", {30'h0, scl_oe, sda_oe}, 32'h0);
    check("drive levels", {30'h0, scl_out, sda_out}, 32'h0);
    // register rows: reset values, mask, unmapped place, two requests at once
    for (int i = 0; i < 11; i++) begin
      if (rows[i].wr) reg_wr(rows[i].addr, rows[i].data);
      else reg_rd(rows[i].addr, rd);
      if (!rows[i].wr) check("row", rd, rows[i].exp);
    end
    // frame built from single segments: start, send, send, receive, stop
    reg_wr(`OFS_CTRL_ONE, 32'h1);
    wait_idle();
    chk_reg("status start", `OFS_STATUS, 32'h1);
    chk_reg("flags start", `OFS_INT_FLAGS, 32'h1);
    irq_is(1'b1);
    reg_wr(`OFS_INT_MASK, 32'h3E);
    irq_is(1'b0);
    reg_wr(`OFS_INT_MASK, 32'h3F);
    irq_is(1'b1);
    reg_wr(`OFS_INT_FLAGS, 32'h3F);
    irq_is(1'b0);
    // 10-bit header 0x1E, high address bits 01, write; slave stretches every bit after the first
    stretch <= 1'b1;
    reg_wr(`OFS_DATA, 32'hF2);
    reg_wr(`OFS_CTRL_ONE, 32'h2);
    reg_wr(`OFS_CTRL_ONE, 32'h8);
    chk_reg("ctrl_one pending", `OFS_CTRL_ONE, 32'h2);
    wait_idle();
    check("byte on wire", {24'h0, got_byte}, 32'hF2);
    chk_reg("status send", `OFS_STATUS, 32'h2);
    chk_reg("flags send", `OFS_INT_FLAGS, 32'h2);
    reg_wr(`OFS_INT_FLAGS, 32'h3F);
    // second send with no new byte and a slave nack
    stretch  <= 1'b0;
    nack_cmd <= 1'b1;
    reg_wr(`OFS_CTRL_ONE, 32'h2);
    wait_idle();
    check("byte resent", {24'h0, got_byte}, 32'hF2);
    chk_reg("status nack", `OFS_STATUS, 32'hA);
    chk_reg("flags nack", `OFS_INT_FLAGS, 32'h2A);
    reg_wr(`OFS_INT_FLAGS, 32'h3F);
    // receive with ack_select set: the master must pull the ack slot low
    tx_mode  <= 1'b1;
    nack_cmd <= 1'b0;
    reg_wr(`OFS_CTRL_ONE, 32'h4);
    wait_idle();
    chk_reg("status recv", `OFS_STATUS, 32'h4);
    chk_reg("flags recv", `OFS_INT_FLAGS, 32'h4);
    check("ack level", {31'h0, ack_seen}, 32'h0);
    chk_reg("rx byte", `OFS_DATA, 32'h5A);
    reg_wr(`OFS_INT_FLAGS, 32'h3F);
    tx_mode <= 1'b0;
    reg_wr(`OFS_CTRL_ONE, 32'h8);
    wait_idle();
    chk_reg("status stop", `OFS_STATUS, 32'h1);
    check("lines after stop", {30'h0, scl_oe, sda_oe}, 32'h0);
    irq_is(1'b1);
    // second reset in mid-run drops the event and the mask
    resetn <= 1'b0;
    repeat (2) @(posedge clock);
    #1 check("irq in reset", {31'h0, irq}, 32'h0);
    check("lines in reset", {30'h0, scl_oe, sda_oe}, 32'h0);
    resetn <= 1'b1;
    chk_reg("mask after reset", `OFS_INT_MASK, 32'h0);
    summarize();
  end
endmodule : i2c_master_segment_controller_test

`default_nettype wire
